// File: inc/bcc_pkg.sv
// bcc_pkg: constants and types for the bus cycle command controller.
// assumes one core clock at twice the bus master's processor clock.
package bcc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SYNC_STAGES   = 2;

  // input vector bit positions after synchronisation
  localparam int unsigned IN_W      = 9;
  localparam int unsigned IN_S0     = 0;
  localparam int unsigned IN_S1     = 1;
  localparam int unsigned IN_MIO    = 2;
  localparam int unsigned IN_READY  = 3;
  localparam int unsigned IN_CMDDLY = 4;
  localparam int unsigned IN_SEL    = 5;
  localparam int unsigned IN_GRANT  = 6;
  localparam int unsigned IN_STRAP  = 7;
  localparam int unsigned IN_SPARE  = 8;

  // command-state and grant-edge clock counts
  localparam logic [1:0] TC_CNT_MAX   = 2'h3;
  localparam logic [1:0] RD_CMD_DLY_0 = 2'h0;
  localparam logic [1:0] RD_CMD_DLY_1 = 2'h1;
  localparam logic [1:0] WR_CMD_DLY_0 = 2'h0;
  localparam logic [1:0] WR_CMD_DLY_1 = 2'h2;
  localparam logic [1:0] WR_DEN_DLY_1 = 2'h0;
  localparam logic [1:0] MCE_EXTRA    = 2'h0;
  localparam logic [1:0] GRANT_EDGES  = 2'h3;

  // output reset values
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_DIR      = 1'b1;
  localparam logic RST_DEN      = 1'b0;
  localparam logic RST_ALE      = 1'b0;
  localparam logic RST_MCE      = 1'b0;
  localparam logic RST_DRIVE    = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_STAT = 3'h2,
    ST_CMD  = 3'h4
  } bcc_state_t;

  // cycle code is {memory/io select, status bit 1, status bit 0}
  typedef enum logic [2:0] {
    CYC_INTERRUPT_ACK_STROBE  = 3'h0,
    CYC_IORD  = 3'h1,
    CYC_IOWR  = 3'h2,
    CYC_IDLE0 = 3'h3,
    CYC_HALT  = 3'h4,
    CYC_MRD   = 3'h5,
    CYC_MWR   = 3'h6,
    CYC_IDLE1 = 3'h7
  } bcc_cycle_t;

endpackage : bcc_pkg

// File: src/bcc_bus_cycle_ctrl.sv
// bcc_bus_cycle_ctrl: decodes bus master status into timed command strobes,
// address latch, cascade enable and transceiver controls.
// assumes all pin inputs are asynchronous; they are synchronised first,
// so responses lag the pins by the synchroniser depth plus one clock, or plus two through the state register.
`timescale 1ns/1ns
// Behaviour
// - status state is followed by command state; repeated command states are wait states
// - ready sampled at end of each command state; high repeats it, low ends cycle
// - command and control outputs hold steady during wait states, except a strap-high write strobe, which starts in the first one
// - new status seen at end of ended command state goes straight to status
// - select and status bits decode into cycle kind; direction low only for reads
// - latch strobe and transceiver enable only for reads/writes; cascade only for acknowledge
// - all reads share one timing, all writes another; only strobe differs
// - halt drives nothing and ignores control inputs until next status
// - strap high delays command and write enable; strap low adds no delay
// - back-to-back cycles keep the same relative output timing
// - strap low: direction and enable stay high between consecutive writes
// - strap high: read strobes activate one clock later
// - strap high: write strobes activate two clocks later
// - strap high: write transceiver enable rises one clock later
// - strap high: transceiver enable always drops between cycles
// - latch strobe in second half of status state, unaffected by inputs
// - cascade enable lasts one clock longer than latch strobe when selected; unselected, both last one clock
// - select sampled at end of status; low keeps commands off, direction high after the status state
// - unselected cycle ignores delay, enable and ready until next status
// - select input is latched internally
// - strap low: write enable rises in status phase 2, dropped if unselected
// - shared-bus cycle needs both select and arbiter grant
// - idle, status and command states; cycle starts on either status low
// - delay input sampled from end of status until seen low
// - strap high: grant loss floats commands, grant gives enable then commands 3 edges later
// - strap low: enable low forces commands and transceiver enable inactive
module bcc_bus_cycle_ctrl #(
  parameter int unsigned SYNC_STAGES = bcc_pkg::SYNC_STAGES
) (
  input  wire logic CORE_CLK_I,
  input  wire logic RESETN_I,
  input  wire logic STATUS_BIT_0_N_I,
  input  wire logic STATUS_BIT_1_N_I,
  input  wire logic MEM_IO_SELECT_I,
  input  wire logic READY_N_I,
  input  wire logic COMMAND_DELAY_INPUT_I,
  input  wire logic LATCHED_CYCLE_SELECT_I,
  input  wire logic COMMAND_ENABLE_OR_GRANT_I,
  input  wire logic SYSTEM_BUS_TIMING_STRAP_I,
  output logic      INTERRUPT_ACK_STROBE_N_O,
  output logic      IO_READ_STROBE_N_O,
  output logic      IO_WRITE_STROBE_N_O,
  output logic      MEMORY_READ_STROBE_N_O,
  output logic      MEMORY_WRITE_STROBE_N_O,
  output logic      COMMAND_DRIVE_EN_O,
  output logic      ADDR_LATCH_STROBE_O,
  output logic      CASCADE_ADDRESS_ENABLE_O,
  output logic      TRANSCEIVER_ENABLE_O,
  output logic      TRANSFER_DIRECTION_O
);
  import bcc_pkg::*;

  function automatic logic is_read(input bcc_cycle_t k);
    is_read = (k == CYC_INTERRUPT_ACK_STROBE) || (k == CYC_IORD) || (k == CYC_MRD);
  endfunction : is_read

  function automatic logic is_write(input bcc_cycle_t k);
    is_write = (k == CYC_IOWR) || (k == CYC_MWR);
  endfunction : is_write

  // synchroniser: only the last stage is read by logic
  logic [IN_W-1:0] in_raw;
  logic [IN_W-1:0] sync_q [SYNC_STAGES];
  logic [IN_W-1:0] in_s;

  assign in_raw = {1'b0, SYSTEM_BUS_TIMING_STRAP_I, COMMAND_ENABLE_OR_GRANT_I,
                   LATCHED_CYCLE_SELECT_I, COMMAND_DELAY_INPUT_I, READY_N_I,
                   MEM_IO_SELECT_I, STATUS_BIT_1_N_I, STATUS_BIT_0_N_I};

  genvar g;
  generate
    for (g = 0; g < SYNC_STAGES; g++) begin : g_sync
      always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          sync_q[g] <= '1;
        end else if (g == 0) begin
          sync_q[g] <= in_raw;
        end else begin
          sync_q[g] <= sync_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign in_s = sync_q[SYNC_STAGES-1];

  logic       strap_s;
  logic       grant_n_s;
  logic       stat_act;
  logic       new_cycle;
  bcc_cycle_t kind_dec;

  assign strap_s   = in_s[IN_STRAP];
  assign grant_n_s = in_s[IN_GRANT];
  assign stat_act  = ~in_s[IN_S1] | ~in_s[IN_S0];
  assign kind_dec  = bcc_cycle_t'({in_s[IN_MIO], in_s[IN_S1], in_s[IN_S0]});

  // edge on status, so a status held over two clocks starts only one cycle
  logic stat_prev_q;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stat_prev_q <= 1'b0;
    end else begin
      stat_prev_q <= stat_act;
    end
  end
  assign new_cycle = stat_act & ~stat_prev_q;

  // bus state machine
  bcc_state_t state_q;
  bcc_state_t state_d;
  bcc_cycle_t kind_q;
  logic [1:0] tc_cnt_q;
  logic       tc_ph2_q;
  logic       rw_cyc;

  assign rw_cyc = is_read(kind_q) | is_write(kind_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (new_cycle) begin
          state_d = ST_STAT;
        end
      end
      ST_STAT: begin
        // halt and unselected cycles leave the rest of the cycle to the status edge
        if (rw_cyc && in_s[IN_SEL]) begin
          state_d = ST_CMD;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_CMD: begin
        if (tc_ph2_q && !in_s[IN_READY]) begin
          state_d = new_cycle ? ST_STAT : ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      kind_q <= CYC_IDLE1;
    end else if (state_d == ST_STAT && state_q != ST_STAT) begin
      kind_q <= kind_dec;
    end
  end

  // clocks spent in command state; saturates so wait states change nothing
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tc_cnt_q <= 2'h0;
      tc_ph2_q <= 1'b0;
    end else if (state_q != ST_CMD) begin
      tc_cnt_q <= 2'h0;
      tc_ph2_q <= 1'b0;
    end else begin
      tc_ph2_q <= ~tc_ph2_q;
      if (tc_cnt_q != TC_CNT_MAX) begin
        tc_cnt_q <= tc_cnt_q + 2'h1;
      end
    end
  end

  // select and command delay, captured at the end of status
  logic sel_q;
  logic cmd_ok_q;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sel_q <= 1'b0;
    end else if (state_q == ST_STAT) begin
      sel_q <= in_s[IN_SEL] & rw_cyc;
    end else if (state_q == ST_IDLE) begin
      sel_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cmd_ok_q <= 1'b0;
    end else if (state_q == ST_STAT) begin
      cmd_ok_q <= ~in_s[IN_CMDDLY];
    end else if (state_q == ST_CMD) begin
      cmd_ok_q <= cmd_ok_q | ~in_s[IN_CMDDLY];
    end else begin
      cmd_ok_q <= 1'b0;
    end
  end

  // edges since the arbiter granted the shared bus
  logic [1:0] grant_cnt_q;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      grant_cnt_q <= 2'h0;
    end else if (grant_n_s) begin
      grant_cnt_q <= 2'h0;
    end else if (grant_cnt_q != GRANT_EDGES) begin
      grant_cnt_q <= grant_cnt_q + 2'h1;
    end
  end

  // output decode
  logic rd;
  logic wr;
  logic in_stat;
  logic in_cmd;
  logic en_ok;
  logic cmd_allow;
  logic cmd_time;
  logic cmd_on;
  logic den_d;
  logic dir_d;
  logic ale_d;
  logic mce_d;

  always_comb begin
    rd      = is_read(kind_q);
    wr      = is_write(kind_q);
    in_stat = (state_q == ST_STAT);
    in_cmd  = (state_q == ST_CMD);
    // strap high: grant active low; strap low: enable active high
    en_ok   = strap_s ? ~grant_n_s : in_s[IN_GRANT];
    cmd_allow = sel_q & cmd_ok_q &
                (strap_s ? (grant_cnt_q == GRANT_EDGES) : en_ok);
    if (rd) begin
      cmd_time = tc_cnt_q >= (strap_s ? RD_CMD_DLY_1 : RD_CMD_DLY_0);
    end else begin
      cmd_time = tc_cnt_q >= (strap_s ? WR_CMD_DLY_1 : WR_CMD_DLY_0);
    end
    cmd_on = in_cmd & cmd_allow & cmd_time & (rd | wr);
    if (rd) begin
      den_d = in_cmd & sel_q & en_ok;
    end else if (wr && !strap_s) begin
      den_d = (in_stat | (in_cmd & sel_q)) & en_ok;
    end else if (wr) begin
      den_d = in_cmd & sel_q & en_ok &
              (tc_cnt_q >= WR_DEN_DLY_1);
    end else begin
      den_d = 1'b0;
    end
    dir_d = ~(rd & (in_stat | (in_cmd & sel_q)));
    ale_d = in_stat & (rd | wr);
    mce_d = (kind_q == CYC_INTERRUPT_ACK_STROBE) &
            (in_stat | (in_cmd & (tc_cnt_q == MCE_EXTRA)));
  end

  // registered outputs, one per concern
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      INTERRUPT_ACK_STROBE_N_O <= RST_STROBE_N;
      IO_READ_STROBE_N_O       <= RST_STROBE_N;
      IO_WRITE_STROBE_N_O      <= RST_STROBE_N;
      MEMORY_READ_STROBE_N_O   <= RST_STROBE_N;
      MEMORY_WRITE_STROBE_N_O  <= RST_STROBE_N;
    end else begin
      INTERRUPT_ACK_STROBE_N_O <= ~(cmd_on & (kind_q == CYC_INTERRUPT_ACK_STROBE));
      IO_READ_STROBE_N_O       <= ~(cmd_on & (kind_q == CYC_IORD));
      IO_WRITE_STROBE_N_O      <= ~(cmd_on & (kind_q == CYC_IOWR));
      MEMORY_READ_STROBE_N_O   <= ~(cmd_on & (kind_q == CYC_MRD));
      MEMORY_WRITE_STROBE_N_O  <= ~(cmd_on & (kind_q == CYC_MWR));
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      COMMAND_DRIVE_EN_O <= RST_DRIVE;
    end else begin
      // float only in shared-bus mode while the bus is not ours
      COMMAND_DRIVE_EN_O <= ~(strap_s & grant_n_s);
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TRANSCEIVER_ENABLE_O <= RST_DEN;
      TRANSFER_DIRECTION_O <= RST_DIR;
    end else begin
      TRANSCEIVER_ENABLE_O <= den_d;
      TRANSFER_DIRECTION_O <= dir_d;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ADDR_LATCH_STROBE_O      <= RST_ALE;
      CASCADE_ADDRESS_ENABLE_O <= RST_MCE;
    end else begin
      ADDR_LATCH_STROBE_O      <= ale_d;
      CASCADE_ADDRESS_ENABLE_O <= mce_d;
    end
  end

endmodule : bcc_bus_cycle_ctrl

// File: tb/bcc_cpu_model.sv
// bcc_cpu_model: local bus master issuing one status state per request.
// assumes requests are spaced by the bench; status lines idle high.
`timescale 1ns/1ns
module bcc_cpu_model (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              go_i,
  input  wire bcc_pkg::bcc_cycle_t code_i,
  output logic                   s0_n_o,
  output logic                   s1_n_o,
  output logic                   mio_o
);
  import bcc_pkg::*;
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 2'h0;
      s0_n_o <= 1'b1;
      s1_n_o <= 1'b1;
      mio_o  <= 1'b0;
    end else if (go_i) begin
      cnt_q                   <= 2'h2;
      {mio_o, s1_n_o, s0_n_o} <= code_i;
    end else if (cnt_q == 2'h1) begin
      cnt_q            <= 2'h0;
      {s1_n_o, s0_n_o} <= 2'h3;
      // address side moves on the same edge that returns the status lines high, before the latch strobe
      mio_o            <= ~mio_o;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule : bcc_cpu_model

// File: tb/bcc_bus_cycle_ctrl_asserts.sv
// bcc_bus_cycle_ctrl_asserts: port-level checker for the cycle controller.
// assumes pins settle through the two-stage input synchroniser.
`timescale 1ns/1ns
module bcc_bus_cycle_ctrl_asserts #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic READY_N_I,
  input wire logic COMMAND_ENABLE_OR_GRANT_I,
  input wire logic SYSTEM_BUS_TIMING_STRAP_I,
  input wire logic INTERRUPT_ACK_STROBE_N_O,
  input wire logic IO_READ_STROBE_N_O,
  input wire logic IO_WRITE_STROBE_N_O,
  input wire logic MEMORY_READ_STROBE_N_O,
  input wire logic MEMORY_WRITE_STROBE_N_O,
  input wire logic COMMAND_DRIVE_EN_O,
  input wire logic ADDR_LATCH_STROBE_O,
  input wire logic CASCADE_ADDRESS_ENABLE_O,
  input wire logic TRANSCEIVER_ENABLE_O,
  input wire logic TRANSFER_DIRECTION_O
);
  import bcc_pkg::*;
  logic [4:0] cmd;
  logic [2:0] age_q, rdy_q, gnt_q, stp_q;
  logic       old, rdy_hi, gnt_hi, gnt_lo, stp_hi, stp_lo;
  assign cmd = {INTERRUPT_ACK_STROBE_N_O, IO_READ_STROBE_N_O, IO_WRITE_STROBE_N_O,
                MEMORY_READ_STROBE_N_O, MEMORY_WRITE_STROBE_N_O};
  // history hides pre-reset pin values from the window checks
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    rdy_q <= {rdy_q[1:0], READY_N_I};
    gnt_q <= {gnt_q[1:0], COMMAND_ENABLE_OR_GRANT_I};
    stp_q <= {stp_q[1:0], SYSTEM_BUS_TIMING_STRAP_I};
  end
  assign old    = age_q == 3'h7;
  assign rdy_hi = old && READY_N_I && (&rdy_q);
  assign gnt_hi = old && COMMAND_ENABLE_OR_GRANT_I && (&gnt_q);
  assign gnt_lo = old && !COMMAND_ENABLE_OR_GRANT_I && !(|gnt_q);
  assign stp_hi = old && SYSTEM_BUS_TIMING_STRAP_I && (&stp_q);
  assign stp_lo = old && !SYSTEM_BUS_TIMING_STRAP_I && !(|stp_q);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_ale_pulse: assert property ($rose(ADDR_LATCH_STROBE_O) |=> !ADDR_LATCH_STROBE_O)
    else $error("latch strobe longer than one clock");
  a_mce_two: assert property ($rose(CASCADE_ADDRESS_ENABLE_O) |=>
    CASCADE_ADDRESS_ENABLE_O ##1 !CASCADE_ADDRESS_ENABLE_O) else $error("cascade length wrong");
  a_one_cmd: assert property ($onehot0(~cmd)) else $error("two strobes active");
  a_wait_hold: assert property (rdy_hi && (gnt_hi || gnt_lo) && cmd != 5'h1f |=>
    cmd == $past(cmd) && $stable(TRANSCEIVER_ENABLE_O) && $stable(TRANSFER_DIRECTION_O))
    else $error("outputs moved in wait state");
  a_ale_quiet: assert property (ADDR_LATCH_STROBE_O |-> cmd == 5'h1f)
    else $error("strobe active during latch strobe");
  a_strap_den: assert property (stp_hi && ADDR_LATCH_STROBE_O |-> !TRANSCEIVER_ENABLE_O)
    else $error("enable high between cycles");
  a_grant_float: assert property (stp_hi && gnt_hi |=>
    !COMMAND_DRIVE_EN_O && !TRANSCEIVER_ENABLE_O) else $error("drive kept without grant");
  a_cen_force: assert property (stp_lo && gnt_lo |=>
    cmd == 5'h1f && !TRANSCEIVER_ENABLE_O && COMMAND_DRIVE_EN_O) else $error("enable not forced");
  a_rd_dir: assert property (!(&cmd[4:3]) || !cmd[1] |-> !TRANSFER_DIRECTION_O)
    else $error("direction high in read");
  a_wr_dir: assert property (!cmd[2] || !cmd[0] |->
    TRANSFER_DIRECTION_O && TRANSCEIVER_ENABLE_O) else $error("write controls wrong");
  c_ack: cover property ($rose(CASCADE_ADDRESS_ENABLE_O));
  c_wr_high: cover property (stp_hi && !cmd[0]);
  c_float: cover property (old && !COMMAND_DRIVE_EN_O);
endmodule : bcc_bus_cycle_ctrl_asserts
bind bcc_bus_cycle_ctrl bcc_bus_cycle_ctrl_asserts #(.SYNC_STAGES(SYNC_STAGES)) i_asserts (.*);

// File: tb/bcc_bus_cycle_ctrl_tb_top.sv
// bcc_bus_cycle_ctrl_tb_top: scenario bench for the cycle controller.
// assumes the cpu model drives status; ready, strap and enables come from here.
`timescale 1ns/1ns
module bcc_bus_cycle_ctrl_tb_top;
  import bcc_pkg::*;
  logic CORE_CLK_I, RESETN_I, STATUS_BIT_0_N_I, STATUS_BIT_1_N_I, MEM_IO_SELECT_I;
  logic READY_N_I, COMMAND_DELAY_INPUT_I, LATCHED_CYCLE_SELECT_I;
  logic COMMAND_ENABLE_OR_GRANT_I, SYSTEM_BUS_TIMING_STRAP_I, go, dl;
  logic INTERRUPT_ACK_STROBE_N_O, IO_READ_STROBE_N_O, IO_WRITE_STROBE_N_O;
  logic MEMORY_READ_STROBE_N_O, MEMORY_WRITE_STROBE_N_O, COMMAND_DRIVE_EN_O;
  logic ADDR_LATCH_STROBE_O, CASCADE_ADDRESS_ENABLE_O, TRANSCEIVER_ENABLE_O;
  logic TRANSFER_DIRECTION_O;
  logic [4:0] cmd, cv;
  bcc_cycle_t code;
  int         n_fail, num_checks, ta, tc, td, nm;
  assign cmd = {INTERRUPT_ACK_STROBE_N_O, IO_READ_STROBE_N_O, IO_WRITE_STROBE_N_O,
                MEMORY_READ_STROBE_N_O, MEMORY_WRITE_STROBE_N_O};
  bcc_bus_cycle_ctrl #(.SYNC_STAGES(2)) i_dut (.*);
  bcc_cpu_model i_cpu (.clk_i(CORE_CLK_I), .rst_n_i(RESETN_I), .go_i(go), .code_i(code),
    .s0_n_o(STATUS_BIT_0_N_I), .s1_n_o(STATUS_BIT_1_N_I), .mio_o(MEM_IO_SELECT_I));
  always #50 CORE_CLK_I = ~CORE_CLK_I;
  task automatic tk(input int n);
    repeat (n) @(posedge CORE_CLK_I);
  endtask : tk
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  function automatic logic [4:0] exp_cmd(input int c);
    case (c)
      0: exp_cmd = 5'h0f;
      1: exp_cmd = 5'h17;
      2: exp_cmd = 5'h1b;
      5: exp_cmd = 5'h1d;
      6: exp_cmd = 5'h1e;
      default: exp_cmd = 5'h1f;
    endcase
  endfunction : exp_cmd
  // one cycle; ready answers three clocks after the strobe, so waits occur
  task automatic cyc(input int c, input logic s);
    int rd;
    ta = -1; tc = -1; td = -1; nm = 0; cv = 5'h1f; dl = 1'b1; rd = -9;
    LATCHED_CYCLE_SELECT_I <= s;
    code <= bcc_cycle_t'(c);
    go <= 1'b1;
    tk(1);
    go <= 1'b0;
    for (int t = 0; t < 24; t++) begin
      @(posedge CORE_CLK_I);
      READY_N_I <= !(t == rd || t == rd + 1);
      if (ta >= 0) LATCHED_CYCLE_SELECT_I <= 1'b0;
      if (t == 9) COMMAND_DELAY_INPUT_I <= 1'b0;
      #1;
      if (ADDR_LATCH_STROBE_O === 1'b1 && ta < 0) ta = t;
      if (TRANSCEIVER_ENABLE_O === 1'b1 && td < 0) td = t;
      if (CASCADE_ADDRESS_ENABLE_O === 1'b1) nm++;
      if (TRANSFER_DIRECTION_O !== 1'b1) dl = 1'b0;
      if (cmd !== 5'h1f && tc < 0) begin
        tc = t;
        cv = cmd;
        rd = t + 3;
      end
    end
    chk("end", {cmd, TRANSFER_DIRECTION_O, TRANSCEIVER_ENABLE_O}, 10'h7e);
  endtask : cyc
  task automatic t_decode();
    for (int i = 0; i < 8; i++) begin
      cyc(i, 1'b1);
      chk("cmd", cv, exp_cmd(i));
      chk("ale", 10'(ta >= 0), 10'(exp_cmd(i) != 5'h1f));
      chk("mce", 10'(nm), (i == 0) ? 10'h2 : 10'h0);
      chk("dir", 10'(dl), 10'(!(i == 0 || i == 1 || i == 5)));
      // strobe follows the latch strobe by one clock with no delay added
      if (exp_cmd(i) != 5'h1f) chk("lag", 10'(tc - ta), 10'h1);
      if (i == 2 || i == 6) chk("den", 10'(td - ta), 10'h0);
    end
  endtask : t_decode
  task automatic t_delay();
    COMMAND_DELAY_INPUT_I <= 1'b1;
    cyc(5, 1'b1);
    chk("delay", 10'(tc > 9), 10'h1);
    chk("dcmd", cv, 5'h1d);
  endtask : t_delay
  task automatic t_unsel();
    cyc(6, 1'b0);
    chk("ucmd", cv, 5'h1f);
    chk("udir", 10'(dl), 10'h1);
    chk("uale", 10'(ta >= 0), 10'h1);
  endtask : t_unsel
  task automatic t_b2b();
    int dn;
    dn = 0;
    LATCHED_CYCLE_SELECT_I <= 1'b1;
    code <= CYC_MWR;
    go <= 1'b1;
    // second status reaches the controller on the edge that ends the first cycle
    for (int t = 0; t < 12; t++) begin
      @(posedge CORE_CLK_I);
      go        <= (t == 2);
      READY_N_I <= !(t >= 3 && t < 7);
      #1;
      if (t >= 4 && t <= 9 &&
          (TRANSCEIVER_ENABLE_O !== 1'b1 || TRANSFER_DIRECTION_O !== 1'b1)) dn++;
      chk("b2b_cmd", cmd, (t == 5 || t == 6 || t == 8 || t == 9) ? 5'h1e : 5'h1f);
      chk("b2b_ale", 10'(ADDR_LATCH_STROBE_O), 10'(t == 4 || t == 7));
    end
    chk("b2b_den", 10'(dn), 10'h0);
    tk(6);
  endtask : t_b2b
  task automatic t_high();
    SYSTEM_BUS_TIMING_STRAP_I <= 1'b1;
    COMMAND_ENABLE_OR_GRANT_I <= 1'b0;
    tk(6);
    for (int i = 0; i < 8; i++) begin
      if (exp_cmd(i) != 5'h1f) begin
        cyc(i, 1'b1);
        chk("hcmd", cv, exp_cmd(i));
        chk("hlag", 10'(tc - ta), (i == 2 || i == 6) ? 10'h3 : 10'h2);
        if (i == 2 || i == 6) chk("hden", 10'(td - ta), 10'h1);
      end
    end
  endtask : t_high
  task automatic t_grant();
    COMMAND_ENABLE_OR_GRANT_I <= 1'b1;
    tk(6);
    chk("float", {COMMAND_DRIVE_EN_O, TRANSCEIVER_ENABLE_O}, 10'h0);
    COMMAND_ENABLE_OR_GRANT_I <= 1'b0;
    tk(6);
    chk("grant", 10'(COMMAND_DRIVE_EN_O), 10'h1);
    SYSTEM_BUS_TIMING_STRAP_I <= 1'b0;
    tk(6);
    chk("cen", {cmd, COMMAND_DRIVE_EN_O}, 10'h3f);
  endtask : t_grant
  initial begin
    CORE_CLK_I = 1'b0;
    RESETN_I = 1'b0;
    READY_N_I = 1'b1;
    COMMAND_DELAY_INPUT_I = 1'b0;
    LATCHED_CYCLE_SELECT_I = 1'b1;
    COMMAND_ENABLE_OR_GRANT_I = 1'b1;
    SYSTEM_BUS_TIMING_STRAP_I = 1'b0;
    go = 1'b0;
    code = CYC_IDLE1;
    n_fail = 0;
    num_checks = 0;
    tk(7);
    #1;
    chk("reset", {cmd, TRANSFER_DIRECTION_O, TRANSCEIVER_ENABLE_O, ADDR_LATCH_STROBE_O,
      CASCADE_ADDRESS_ENABLE_O, COMMAND_DRIVE_EN_O}, 10'h3f1);
    tk(1);
    RESETN_I <= 1'b1;
    tk(6);
    t_decode();
    t_delay();
    t_unsel();
    t_b2b();
    t_high();
    t_grant();
    stop_test();
  end
endmodule : bcc_bus_cycle_ctrl_tb_top
